// [core/seq_map.svh]
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

// Instruction cycle length in system clocks
`define SYS_PER_INSTR 4

// Program counter load values
`define VEC_RESET 9'h000
`define VEC_EXT 9'h004
`define VEC_TMR 9'h008

// Data memory map
`define DM_INDIRECT 7'h00
`define DM_MEM_PTR 7'h01
`define DM_PC_LOW 7'h06
`define DM_LOOKUP_PTR 7'h07
`define DM_LOOKUP_HIGH 7'h08
`define DM_RAM_BASE 7'h60
`define DM_RAM_TOP 7'h7f
`define RAM_WORDS 32

// APB register indices, byte address is index times four
`define IDX_PC_LOW 6'h06
`define IDX_LOOKUP_PTR 6'h07
`define IDX_LOOKUP_HIGH 6'h08
`define IDX_PROG_ADDR 6'h10
`define IDX_PROG_DATA 6'h11
`define IDX_CTRL 6'h12
`define IDX_STATUS 6'h13

// Run field position and last page bit value
`define CTRL_RUN_BIT 0
`define LAST_PAGE_BIT 1'b1

`endif

// [core/seq_pkg.sv]
package seq_pkg;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_REFILL = 3'b010,
    ST_TABLE = 3'b100
  } seq_state_t;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_JUMP = 3'h1,
    CMD_CALL = 3'h2,
    CMD_RETURN = 3'h3,
    CMD_RETURN_INT = 3'h4,
    CMD_SKIP = 3'h5,
    CMD_TAB_CUR = 3'h6,
    CMD_TAB_LAST = 3'h7
  } seq_cmd_t;

endpackage : seq_pkg

// [core/program_sequencer.sv]
`include "seq_map.svh"

module program_sequencer import seq_pkg::*; #(
  parameter int PROM_DEPTH = 512,
  parameter int PROM_WIDTH = 14,
  parameter int STACK_LEVELS = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire seq_cmd_t cmd,
  input wire logic [8:0] cmdTarget,
  input wire logic skipTaken,
  input wire logic [6:0] dmAddr,
  input wire logic dmWrite,
  input wire logic [7:0] dmWdata,
  input wire logic dmBitSet,
  input wire logic dmBitClr,
  input wire logic [2:0] dmBitIdx,
  output logic [7:0] dmRdata,
  input wire logic extIntPin_n,
  input wire logic timerOverflow,
  input wire logic intMasterEn,
  input wire logic extIntEn,
  input wire logic timerIntEn,
  output logic [8:0] fetchAddr,
  output logic [13:0] instrWord,
  output logic instrValid,
  output logic cycleStrobe,
  output logic intAckExt,
  output logic intAckTimer
);

  localparam int DW = $clog2(STACK_LEVELS + 1);
  localparam logic [DW-1:0] FULL_DEPTH = DW'(STACK_LEVELS);

  logic [1:0] divCnt_reg;
  logic cycEn_reg;
  logic run_reg;
  logic [8:0] pc_reg;
  logic [13:0] instr_reg;
  logic instrValid_reg;
  seq_state_t state_reg;
  logic [8:0] stack_reg [STACK_LEVELS];
  logic [DW-1:0] depth_reg;
  logic [7:0] lookupPtr_reg;
  logic [5:0] lookupHigh_reg;
  logic [6:0] memPtr_reg;
  logic [7:0] ram [`RAM_WORDS];
  logic [PROM_WIDTH-1:0] prom [PROM_DEPTH];
  logic [8:0] progAddr_reg;
  logic extSync1_reg, extSync2_reg, extPrev_reg;
  logic extPend_reg, tmrPend_reg;
  logic ackExt_reg, ackTmr_reg;
  logic [7:0] dmRdata_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;

  logic exec, stackFull, isTab, isRet, isJump, takeExt, takeTmr, takeInt;
  logic transfer, skipNow, pclWr, dmWrEn, apbPclWr, apbWr, apbRd;
  logic [6:0] effAddr;
  logic [7:0] dmRead, bitMask, dmWrVal, dmWrData;
  logic [8:0] promAddr, tabAddr, pclTarget, stackTop;
  logic [13:0] promWord;
  logic [5:0] promHigh, apbIdx;
  logic [31:0] apbRead;
  logic apbErr;

  // Divider: one instruction cycle every four clocks
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      divCnt_reg <= 2'h0;
      cycEn_reg <= 1'b0;
    end else begin
      divCnt_reg <= divCnt_reg + 2'h1;
      cycEn_reg <= (divCnt_reg == 2'(`SYS_PER_INSTR - 2));
    end
  end

  assign stackFull = (depth_reg == FULL_DEPTH);
  assign stackTop = stack_reg[0];
  assign exec = cycEn_reg && run_reg && (state_reg == ST_RUN) && instrValid_reg;
  assign isTab = exec && (cmd == CMD_TAB_CUR || cmd == CMD_TAB_LAST);
  assign isRet = exec && (cmd == CMD_RETURN || cmd == CMD_RETURN_INT);
  assign isJump = exec && (cmd == CMD_JUMP || cmd == CMD_CALL);
  assign skipNow = exec && (cmd == CMD_SKIP) && skipTaken;
  assign effAddr = (dmAddr == `DM_INDIRECT) ? memPtr_reg : dmAddr;
  assign bitMask = 8'h01 << dmBitIdx;
  assign dmWrVal = dmBitSet ? (dmRead | bitMask) : dmBitClr ? (dmRead & ~bitMask) : dmWdata;
  assign pclWr = exec && (dmWrite || dmBitSet || dmBitClr) && (effAddr == `DM_PC_LOW);

  // Interrupts only at a plain instruction so a transfer never collides
  assign takeExt = exec && (cmd == CMD_NONE) && !pclWr && intMasterEn && extIntEn && extPend_reg
                   && !stackFull;
  assign takeTmr = exec && (cmd == CMD_NONE) && !pclWr && intMasterEn && timerIntEn && tmrPend_reg
                   && !extPend_reg && !stackFull;
  assign takeInt = takeExt || takeTmr;
  assign transfer = takeInt || isJump || isRet || pclWr;

  // Lookup address uses current page bit or forces last page
  assign tabAddr = {(cmd == CMD_TAB_LAST) ? `LAST_PAGE_BIT : pc_reg[8], lookupPtr_reg};
  assign promAddr = isTab ? tabAddr : pc_reg;
  assign promWord = prom[promAddr];
  assign promHigh = promWord[13:8];
  assign dmWrEn = (exec && (dmWrite || dmBitSet || dmBitClr) && effAddr != `DM_INDIRECT) || isTab;
  assign dmWrData = isTab ? promWord[7:0] : dmWrVal;

  always_comb begin
    dmRead = 8'h00;
    if (effAddr >= `DM_RAM_BASE) begin
      dmRead = ram[effAddr[4:0]];
    end else begin
      case (effAddr)
        `DM_MEM_PTR: dmRead = {1'b1, memPtr_reg};
        `DM_PC_LOW: dmRead = pc_reg[7:0];
        `DM_LOOKUP_PTR: dmRead = lookupPtr_reg;
        `DM_LOOKUP_HIGH: dmRead = {2'b00, lookupHigh_reg};
        default: dmRead = 8'h00;
      endcase
    end
  end

  // APB decode
  assign apbIdx = paddr[7:2];
  assign apbWr = psel && penable && pready_reg && pwrite;
  assign apbRd = psel && penable && !pready_reg;
  assign apbPclWr = apbWr && (apbIdx == `IDX_PC_LOW);
  assign pclTarget = {pc_reg[8], pwdata[7:0]};

  always_comb begin
    apbRead = 32'h0;
    apbErr = 1'b0;
    case (apbIdx)
      `IDX_PC_LOW: apbRead = {24'h0, pc_reg[7:0]};
      `IDX_LOOKUP_PTR: apbRead = {24'h0, lookupPtr_reg};
      `IDX_LOOKUP_HIGH: apbRead = {26'h0, lookupHigh_reg};
      `IDX_PROG_ADDR: apbRead = {23'h0, progAddr_reg};
      `IDX_PROG_DATA: apbRead = {18'h0, prom[progAddr_reg]};
      `IDX_CTRL: apbRead = {31'h0, run_reg};
      `IDX_STATUS: apbRead = {27'h0, state_reg, instrValid_reg, stackFull};
      default: apbErr = 1'b1;
    endcase
  end

  // One wait state; data and error settle with pready
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= apbRd;
      pslverr_reg <= apbRd && apbErr;
      if (apbRd && !pwrite) begin
        prdata_reg <= apbRead;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      run_reg <= 1'b0;
      progAddr_reg <= 9'h000;
    end else if (apbWr && apbIdx == `IDX_CTRL) begin
      run_reg <= pwdata[`CTRL_RUN_BIT];
    end else if (apbWr && apbIdx == `IDX_PROG_ADDR) begin
      progAddr_reg <= pwdata[8:0];
    end else if (apbWr && apbIdx == `IDX_PROG_DATA) begin
      progAddr_reg <= progAddr_reg + 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (apbWr && apbIdx == `IDX_PROG_DATA) begin
      prom[progAddr_reg] <= pwdata[PROM_WIDTH-1:0];
    end
  end

  // Program counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pc_reg <= `VEC_RESET;
    end else if (apbPclWr) begin
      pc_reg <= pclTarget;
    end else if (cycEn_reg && run_reg) begin
      if (takeExt) begin
        pc_reg <= `VEC_EXT;
      end else if (takeTmr) begin
        pc_reg <= `VEC_TMR;
      end else if (isJump) begin
        pc_reg <= cmdTarget;
      end else if (isRet) begin
        pc_reg <= stackTop;
      end else if (pclWr) begin
        pc_reg <= {pc_reg[8], dmWrVal};
      end else if (!isTab) begin
        pc_reg <= pc_reg + 9'h001;
      end
    end
  end

  // Fetch pipeline and sequencing state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      instr_reg <= 14'h0000;
      instrValid_reg <= 1'b0;
      state_reg <= ST_REFILL;
    end else if (apbPclWr) begin
      instrValid_reg <= 1'b0;
      state_reg <= ST_REFILL;
    end else if (cycEn_reg && run_reg) begin
      if (transfer) begin
        instrValid_reg <= 1'b0;
        state_reg <= ST_REFILL;
      end else if (isTab) begin
        instrValid_reg <= 1'b0;
        state_reg <= ST_TABLE;
      end else begin
        instr_reg <= promWord;
        instrValid_reg <= !skipNow;
        state_reg <= ST_RUN;
      end
    end
  end

  // Return stack, newest entry at index 0, invisible to software
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      depth_reg <= '0;
      for (int i = 0; i < STACK_LEVELS; i++) begin
        stack_reg[i] <= 9'h000;
      end
    end else if (!apbPclWr && cycEn_reg && run_reg) begin
      if (takeInt || (isJump && cmd == CMD_CALL)) begin
        stack_reg[0] <= pc_reg;
        for (int i = 1; i < STACK_LEVELS; i++) begin
          stack_reg[i] <= stack_reg[i-1];
        end
        if (!stackFull) begin
          depth_reg <= depth_reg + DW'(1);
        end
      end else if (isRet) begin
        for (int i = 0; i < STACK_LEVELS - 1; i++) begin
          stack_reg[i] <= stack_reg[i+1];
        end
        if (depth_reg != '0) begin
          depth_reg <= depth_reg - DW'(1);
        end
      end
    end
  end

  // Interrupt request capture; a new request beats the acknowledge clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      extSync1_reg <= 1'b1;
      extSync2_reg <= 1'b1;
      extPrev_reg <= 1'b1;
      extPend_reg <= 1'b0;
      tmrPend_reg <= 1'b0;
      ackExt_reg <= 1'b0;
      ackTmr_reg <= 1'b0;
    end else begin
      extSync1_reg <= extIntPin_n;
      extSync2_reg <= extSync1_reg;
      extPrev_reg <= extSync2_reg;
      ackExt_reg <= takeExt && !apbPclWr;
      ackTmr_reg <= takeTmr && !apbPclWr;
      if (extPrev_reg && !extSync2_reg) begin
        extPend_reg <= 1'b1;
      end else if (takeExt && !apbPclWr) begin
        extPend_reg <= 1'b0;
      end
      if (timerOverflow) begin
        tmrPend_reg <= 1'b1;
      end else if (takeTmr && !apbPclWr) begin
        tmrPend_reg <= 1'b0;
      end
    end
  end

  // Data memory writes; a bus write to the pointer wins over the core
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lookupPtr_reg <= 8'h00;
      lookupHigh_reg <= 6'h00;
      memPtr_reg <= 7'h00;
    end else begin
      if (apbWr && apbIdx == `IDX_LOOKUP_PTR) begin
        lookupPtr_reg <= pwdata[7:0];
      end else if (dmWrEn && effAddr == `DM_LOOKUP_PTR) begin
        lookupPtr_reg <= dmWrData;
      end
      if (isTab && !apbPclWr) begin
        lookupHigh_reg <= promHigh;
      end
      if (dmWrEn && effAddr == `DM_MEM_PTR) begin
        memPtr_reg <= dmWrData[6:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (dmWrEn && effAddr >= `DM_RAM_BASE) begin
      ram[effAddr[4:0]] <= dmWrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dmRdata_reg <= 8'h00;
    end else begin
      dmRdata_reg <= dmRead;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign dmRdata = dmRdata_reg;
  assign fetchAddr = pc_reg;
  assign instrWord = instr_reg;
  assign instrValid = instrValid_reg;
  assign cycleStrobe = cycEn_reg;
  assign intAckExt = ackExt_reg;
  assign intAckTimer = ackTmr_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_dummy;
    !instrValid_reg [*4];
  endsequence

  sequence seq_vector_push;
    depth_reg == $past(depth_reg) + DW'(1) && stackTop == $past(pc_reg);
  endsequence

  a_pc_increment: assert property (cycEn_reg && run_reg && state_reg != ST_RUN && !apbPclWr
    |=> pc_reg == $past(pc_reg) + 9'h001) else $error("counter did not step after fetch");
  a_skip_dummy: assert property (skipNow && !apbPclWr
    |=> !instrValid_reg && pc_reg == $past(pc_reg) + 9'h001) else $error("skip not discarded");
  a_short_jump: assert property (apbPclWr
    |=> pc_reg == $past(pclTarget) ##0 !instrValid_reg && state_reg == ST_REFILL)
    else $error("low byte jump wrong");
  a_transfer_dummy: assert property (transfer && !apbPclWr
    |=> state_reg == ST_REFILL ##0 seq_dummy) else $error("no dummy after transfer");
  a_reset_start: assert property ($rose(rst_n)
    |-> pc_reg == `VEC_RESET && depth_reg == '0) else $error("reset state wrong");
  a_ext_vector: assert property (takeExt && !apbPclWr
    |=> pc_reg == `VEC_EXT ##0 seq_vector_push ##0 intAckExt) else $error("external vector wrong");
  a_tmr_vector: assert property (takeTmr && !apbPclWr
    |=> pc_reg == `VEC_TMR ##0 seq_vector_push) else $error("timer vector wrong");
  a_jump_load: assert property (isJump && !apbPclWr
    |=> pc_reg == $past(cmdTarget)) else $error("jump target not loaded");
  a_return_load: assert property (isRet && !apbPclWr
    |=> pc_reg == $past(stackTop)) else $error("return address wrong");
  a_table_split: assert property (isTab && !apbPclWr
    |=> lookupHigh_reg == $past(promHigh) && state_reg == ST_TABLE
    ##4 state_reg != ST_TABLE) else $error("table read wrong");
  a_full_hold: assert property (exec && stackFull && extPend_reg && extIntEn && intMasterEn
    |=> extPend_reg && !intAckExt) else $error("interrupt taken on full stack");
  a_overflow_keep: assert property (isJump && cmd == CMD_CALL && stackFull && !apbPclWr
    |=> depth_reg == FULL_DEPTH && stack_reg[1] == $past(stackTop)) else $error("overflow wrong");

endmodule : program_sequencer

// [test/decode_model.sv]
module decode_model import seq_pkg::*; (
  input wire logic [13:0] instrWord,
  input wire logic instrValid,
  output seq_cmd_t cmd,
  output logic [8:0] cmdTarget,
  output logic skipTaken,
  output logic [6:0] dmAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Dummy cycles present no command, so a discarded word never acts
  assign cmd = instrValid ? seq_cmd_t'(instrWord[13:11]) : CMD_NONE;
  assign cmdTarget = instrWord[8:0];
  assign skipTaken = instrWord[9];
  assign dmAddr = instrWord[6:0];
endmodule : decode_model

// [test/program_sequencer_stack_table_read_tb.sv]
`include "seq_map.svh"

module program_sequencer_stack_table_read_tb import seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, skipTaken, extIntPin_n, timerOverflow;
  logic intMasterEn, extIntEn, timerIntEn, instrValid, cycleStrobe, intAckExt, intAckTimer, erv;
  logic [7:0] paddr, dmRdata;
  logic [31:0] pwdata, prdata, rdv;
  seq_cmd_t cmd;
  logic [8:0] cmdTarget, fetchAddr;
  logic [6:0] dmAddr;
  logic [13:0] instrWord;
  int nErrors = 0;
  int checks = 0;
  int nExt = 0;
  int nTmr = 0;
  int i;
  // Program image: address and word, word is {cmd, 1'b0, skip, target}
  // Plain words at 004, 005, 008, 009 let the interrupt vectors nest and return
  logic [8:0] la [22] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h004, 9'h005, 9'h006, 9'h0f0, 9'h120,
    9'h130, 9'h140, 9'h131, 9'h121, 9'h123, 9'h010, 9'h110, 9'h00a, 9'h122, 9'h008, 9'h009,
    9'h124, 9'h1a5};
  logic [13:0] lw [22] = '{14'h3060, 14'h3861, 14'h0060, 14'h0061, 14'h0000, 14'h0000, 14'h08f0,
    14'h1120, 14'h1130, 14'h1140, 14'h1800, 14'h2000, 14'h2a00, 14'h2800, 14'h2a5c, 14'h3f81,
    14'h1800, 14'h0800, 14'h0000, 14'h0000, 14'h0000, 14'h0000};

  program_sequencer program_sequencer_inst (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd(cmd), .cmdTarget(cmdTarget), .skipTaken(skipTaken),
    .dmAddr(dmAddr), .dmWrite(1'b0), .dmWdata(8'h00), .dmBitSet(1'b0), .dmBitClr(1'b0),
    .dmBitIdx(3'h0), .dmRdata(dmRdata), .extIntPin_n(extIntPin_n), .timerOverflow(timerOverflow),
    .intMasterEn(intMasterEn), .extIntEn(extIntEn), .timerIntEn(timerIntEn),
    .fetchAddr(fetchAddr), .instrWord(instrWord), .instrValid(instrValid),
    .cycleStrobe(cycleStrobe), .intAckExt(intAckExt), .intAckTimer(intAckTimer));

  decode_model decode_model_inst (.instrWord(instrWord), .instrValid(instrValid), .cmd(cmd),
    .cmdTarget(cmdTarget), .skipTaken(skipTaken), .dmAddr(dmAddr));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (intAckExt === 1'b1) nExt++;
    if (intAckTimer === 1'b1) nTmr++;
  end

  task automatic finishTest();
    if (nErrors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finishTest

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    paddr <= {idx, 2'b00};
    pwrite <= wr;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      nErrors++;
      finishTest();
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    cmp(rdv, exp);
  endtask : rdc

  // Waits for the instruction at ea to be fetched; ed is the dummy count, -1 searches
  task automatic nextInstr(input logic [8:0] ea, input int ed);
    int d;
    int n;
    d = 0;
    for (n = 0; n < 400; n++) begin
      @(posedge ref_clk);
      if (cycleStrobe === 1'b1) begin
        #1;
        if (instrValid !== 1'b1) d++;
        else if (ed >= 0 || fetchAddr === ea + 9'h001) break;
      end
    end
    if (n == 400) begin
      nErrors++;
      finishTest();
    end
    cmp(32'(fetchAddr), 32'(ea + 9'h001));
    if (ed >= 0) cmp(32'(d), 32'(ed));
  endtask : nextInstr

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    extIntPin_n = 1'b1;
    timerOverflow = 1'b0;
    intMasterEn = 1'b0;
    extIntEn = 1'b0;
    timerIntEn = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 cmp(32'(fetchAddr), 32'h0);
    for (i = 0; i < 22; i++) begin
      apb(1'b1, `IDX_PROG_ADDR, 32'(la[i]));
      apb(1'b1, `IDX_PROG_DATA, 32'(lw[i]));
    end
    apb(1'b1, `IDX_LOOKUP_PTR, 32'h10);
    apb(1'b1, `IDX_CTRL, 32'h1);
    nextInstr(9'h000, -1);
    nextInstr(9'h001, 1);
    nextInstr(9'h002, 1);
    @(posedge ref_clk);
    #1 cmp(32'(dmRdata), 32'h5c);
    nextInstr(9'h003, 0);
    @(posedge ref_clk);
    #1 cmp(32'(dmRdata), 32'h81);
    rdc(`IDX_LOOKUP_HIGH, 32'h3f);
    nextInstr(9'h0f0, -1);
    nextInstr(9'h120, 1);
    nextInstr(9'h130, 1);
    nextInstr(9'h140, 1);
    nextInstr(9'h131, 1);
    nextInstr(9'h121, 1);
    nextInstr(9'h123, 1);
    nextInstr(9'h124, 0);
    apb(1'b1, `IDX_CTRL, 32'h0);
    apb(1'b1, `IDX_PC_LOW, 32'ha5);
    #1 cmp(32'(fetchAddr), 32'h1a5);
    rdc(`IDX_PC_LOW, 32'ha5);
    apb(1'b1, `IDX_LOOKUP_HIGH, 32'h0);
    rdc(`IDX_LOOKUP_HIGH, 32'h3f);
    rdc(`IDX_LOOKUP_PTR, 32'h10);
    apb(1'b0, 6'h3f, 32'h0);
    cmp(32'(erv), 32'h1);
    intMasterEn <= 1'b1;
    extIntEn <= 1'b1;
    timerIntEn <= 1'b1;
    extIntPin_n <= 1'b0;
    apb(1'b1, `IDX_CTRL, 32'h1);
    nextInstr(9'h004, -1);
    @(posedge ref_clk);
    timerOverflow <= 1'b1;
    @(posedge ref_clk);
    timerOverflow <= 1'b0;
    extIntPin_n <= 1'b1;
    nextInstr(9'h008, -1);
    // Stack now full, so a new edge must wait for the return at 00a
    extIntPin_n <= 1'b0;
    nextInstr(9'h009, 0);
    nextInstr(9'h00a, 0);
    nextInstr(9'h004, -1);
    cmp(32'(nExt), 32'h2);
    cmp(32'(nTmr), 32'h1);
    finishTest();
  end
endmodule : program_sequencer_stack_table_read_tb
